// file: seep_params.svh
// Shared constants for the serial EEPROM program-control link and both of its ends.
`ifndef SEEP_PARAMS_SVH
`define SEEP_PARAMS_SVH

`define SEEP_ADDR_W 6
`define SEEP_WORD_W 16
`define SEEP_START_BIT 1'h1

`define SEEP_OP_MISC 2'h0
`define SEEP_OP_WRITE 2'h1
`define SEEP_OP_READ 2'h2
`define SEEP_OP_ERASE 2'h3

`define SEEP_EXT_LOCK 2'h0
`define SEEP_EXT_WALL 2'h1
`define SEEP_EXT_EALL 2'h2
`define SEEP_EXT_UNLOCK 2'h3

`define SEEP_ERASED 16'hFFFF

`define SEEP_CLK_HZ 25000000
`define SEEP_PROG_MS 10
`define SEEP_PWR_MS 20
`define SEEP_CS_LOW_NS 500
`define SEEP_SK_HALF 2
`define SEEP_PAD_BITS 0
`define SEEP_POLL_SETTLE 8

`endif

// file: seep_pkg.sv
// Types shared by the serial EEPROM program-control ends.
package seep_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_HDR,
    RX_DATA,
    RX_LATCH,
    RX_DONE
  } seep_rx_t;

  typedef enum logic [1:0] {
    PG_WRITE,
    PG_ERASE,
    PG_WALL,
    PG_EALL
  } seep_prog_t;

  typedef enum logic [2:0] {
    HC_LOCK,
    HC_UNLOCK,
    HC_ERASE,
    HC_WRITE,
    HC_WALL,
    HC_EALL
  } seep_cmd_t;

  typedef enum logic [2:0] {
    H_PWR,
    H_IDLE,
    H_SHIFT,
    H_GAP,
    H_POLL
  } seep_host_t;

endpackage : seep_pkg

// file: seep_if.sv
// Four-wire serial link (select, clock, data in, data out) between the host controller and the EEPROM device.
`timescale 1ns/10ps
interface seep_if;
  logic cs;
  logic sk;
  logic di;
  logic do_val;
  logic do_oe;
  logic do_pin;

  // The data-out wire has a pull-up, so an undriven pin reads high.
  assign do_pin = do_oe ? do_val : 1'h1;

  modport dev (input cs, input sk, input di, output do_val, output do_oe);
  modport host (output cs, output sk, output di, input do_pin);
endinterface : seep_if

// file: seep_sync.sv
// Two-flop synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/10ps
module seep_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [W-1:0] d, // Signals from the other domain.
  output logic [W-1:0] q // Synchronised copy.
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : seep_sync

// file: seep_dev.sv
// Device end: frame receiver on the serial clock and program engine on the core clock.
//
// What this block and the host do
// RULE1: Word erase sets addressed word to ones.
// RULE2: Word erase starts when select falls.
// RULE3: Write-all programs one pattern everywhere.
// RULE4: Write-all frame has sixteen data bits.
// RULE5: Erase-all sets array to ones.
// RULE6: Unlock allows programming, lock blocks it.
// RULE7: Program latch is locked after power-up.
// RULE8: Lock change on edge after last address.
// RULE9: Host waits 20 ms, select low.
// RULE10: Low data before start is dummy.
// RULE11: Host holds data low while polling.
// RULE12: High data when ready starts command.
// RULE13: Select low abandons an unfinished command.
// RULE14: Select low at fifteenth bit cancels.
// RULE15: Bits past sixteen ignored, write kept.
// RULE16: Opcode 00 splits by top address bits.
// RULE17: First high data bit is start.
// RULE18: Data-out low busy, high ready.
// RULE19: Programming ends in 10 ms, inputs ignored.
// RULE20: Commands while locked are silently discarded.
`timescale 1ns/10ps
`include "seep_params.svh"
module seep_dev
  import seep_pkg::*;
#(
  parameter int AW = `SEEP_ADDR_W,
  parameter int PROG_CYCLES = `SEEP_PROG_MS * (`SEEP_CLK_HZ / 1000)
) (
  input wire logic core_clk, // Core clock, 25 MHz.
  input wire logic rst, // Asynchronous reset, active high (power-on clear).
  seep_if.dev link, // Serial link; link.sk clocks the receiver.
  input wire logic [AW-1:0] rd_addr, // Backdoor read address.
  output logic [`SEEP_WORD_W-1:0] rd_data, // Backdoor read data, one cycle late.
  output logic busy, // Program cycle running.
  output logic unlocked // Program latch state, synchronised.
);
  localparam int DW = `SEEP_WORD_W;
  localparam int HB = 2 + AW;
  localparam int WORDS = 1 << AW;
  localparam int PCW = $clog2(PROG_CYCLES + 1);

  // Serial clock domain.
  logic sk_clr;
  seep_rx_t rx_q;
  logic [4:0] cnt_q;
  logic [HB-1:0] hdr_q;
  logic [DW-1:0] dat_q;
  logic [HB-1:0] hsrc;
  logic [1:0] op_w;
  logic [1:0] ext_w;
  logic is_lockop;
  logic is_data;
  logic is_erase;
  logic hdr_last;
  logic data_last;
  logic commit;
  logic busy_sk;
  logic unlock_q;
  logic cmd_tgl_q;
  logic start_tgl_q;
  seep_prog_t cmd_kind_q;
  logic [AW-1:0] cmd_addr_q;
  logic [DW-1:0] cmd_data_q;
  logic start_ok;

  // Core clock domain.
  logic busy_q;
  logic [PCW-1:0] pcnt_q;
  seep_prog_t pkind_q;
  logic [AW-1:0] paddr_q;
  logic [DW-1:0] pdata_q;
  logic sweep_q;
  logic [AW-1:0] idx_q;
  logic [DW-1:0] pat;
  logic [DW-1:0] mem [WORDS];
  logic cs_s;
  logic cmd_s;
  logic start_s;
  logic unlock_s;
  logic cs_d_q;
  logic cmd_seen_q;
  logic start_seen_q;
  logic cs_fall;
  logic launch;
  logic verify_q;
  logic do_q;
  logic do_oe_q;

  // Dropping select puts the receiver back to idle at once, whatever it was doing.
  assign sk_clr = rst | ~link.cs; // [RULE13]

  assign hsrc = (rx_q == RX_HDR) ? {hdr_q[HB-2:0], link.di} : hdr_q;
  assign op_w = hsrc[HB-1:HB-2];
  assign ext_w = hsrc[HB-3:HB-4];
  assign is_lockop = (op_w == `SEEP_OP_MISC) && ((ext_w == `SEEP_EXT_LOCK) || (ext_w == `SEEP_EXT_UNLOCK)); // [RULE16]
  assign is_data = (op_w == `SEEP_OP_WRITE) || ((op_w == `SEEP_OP_MISC) && (ext_w == `SEEP_EXT_WALL)); // [RULE16]
  assign is_erase = (op_w == `SEEP_OP_ERASE) || ((op_w == `SEEP_OP_MISC) && (ext_w == `SEEP_EXT_EALL)); // [RULE16]
  assign hdr_last = (rx_q == RX_HDR) && (cnt_q == 5'(HB - 1));
  assign data_last = (rx_q == RX_DATA) && (cnt_q == 5'(DW - 1));
  // Only a frame that reached its last bit is ever handed over; a shorter one dies with select.
  assign commit = unlock_q && ((hdr_last && is_erase) || data_last); // [RULE20] [RULE14]
  assign start_ok = (rx_q == RX_IDLE) && link.di && !busy_sk; // [RULE17] [RULE10] [RULE19]

  always_ff @(posedge link.sk or posedge sk_clr) begin
    if (sk_clr) begin
      rx_q <= RX_IDLE;
      cnt_q <= '0;
    end else begin
      case (rx_q)
        RX_IDLE: begin
          if (start_ok) begin // [RULE12]
            rx_q <= RX_HDR;
          end
          cnt_q <= '0;
        end
        RX_HDR: begin
          cnt_q <= cnt_q + 5'h01;
          if (hdr_last) begin
            cnt_q <= '0;
            if (is_lockop) begin
              rx_q <= RX_LATCH;
            end else if (is_data) begin
              rx_q <= RX_DATA; // [RULE4]
            end else begin
              rx_q <= RX_DONE; // [RULE1] [RULE5]
            end
          end
        end
        RX_DATA: begin
          cnt_q <= cnt_q + 5'h01;
          if (data_last) begin
            rx_q <= RX_DONE;
          end
        end
        RX_LATCH: rx_q <= RX_DONE;
        RX_DONE: rx_q <= RX_DONE; // [RULE15]
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge link.sk or posedge sk_clr) begin
    if (sk_clr) begin
      hdr_q <= '0;
      dat_q <= '0;
    end else begin
      if (rx_q == RX_HDR) begin
        hdr_q <= {hdr_q[HB-2:0], link.di};
      end
      if (rx_q == RX_DATA) begin
        dat_q <= {dat_q[DW-2:0], link.di};
      end
    end
  end

  always_ff @(posedge link.sk or posedge rst) begin
    if (rst) begin
      unlock_q <= 1'h0; // [RULE7]
    end else if (rx_q == RX_LATCH) begin
      unlock_q <= (hdr_q[HB-3:HB-4] == `SEEP_EXT_UNLOCK); // [RULE6] [RULE8]
    end
  end

  // The captured command stays still once select falls, because the receiver is held in idle then and cannot commit.
  always_ff @(posedge link.sk or posedge rst) begin
    if (rst) begin
      cmd_tgl_q <= 1'h0;
      cmd_kind_q <= PG_WRITE;
      cmd_addr_q <= '0;
      cmd_data_q <= '0;
    end else if (commit) begin
      cmd_tgl_q <= ~cmd_tgl_q;
      cmd_addr_q <= hsrc[AW-1:0];
      cmd_data_q <= {dat_q[DW-2:0], link.di};
      if (op_w == `SEEP_OP_ERASE) begin
        cmd_kind_q <= PG_ERASE;
      end else if (op_w == `SEEP_OP_WRITE) begin
        cmd_kind_q <= PG_WRITE;
      end else if (ext_w == `SEEP_EXT_WALL) begin
        cmd_kind_q <= PG_WALL;
      end else begin
        cmd_kind_q <= PG_EALL;
      end
    end
  end

  always_ff @(posedge link.sk or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'h0;
    end else if (start_ok) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  seep_sync #(.W(1)) u_busy_sync (
    .clk(link.sk),
    .rst(rst),
    .d(busy_q),
    .q(busy_sk)
  );

  seep_sync #(.W(4)) u_core_sync (
    .clk(core_clk),
    .rst(rst),
    .d({link.cs, cmd_tgl_q, start_tgl_q, unlock_q}),
    .q({cs_s, cmd_s, start_s, unlock_s})
  );

  assign cs_fall = cs_d_q && !cs_s;
  assign launch = cs_fall && (cmd_s != cmd_seen_q) && !busy_q; // [RULE2] [RULE4] [RULE5]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_d_q <= 1'h0;
      cmd_seen_q <= 1'h0;
      start_seen_q <= 1'h0;
    end else begin
      cs_d_q <= cs_s;
      start_seen_q <= start_s;
      if (cs_fall) begin
        cmd_seen_q <= cmd_s;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'h0;
      pcnt_q <= '0;
      pkind_q <= PG_WRITE;
      paddr_q <= '0;
      pdata_q <= '0;
    end else if (launch) begin
      busy_q <= 1'h1;
      pcnt_q <= '0;
      pkind_q <= cmd_kind_q;
      paddr_q <= cmd_addr_q;
      pdata_q <= cmd_data_q;
    end else if (busy_q) begin
      if (pcnt_q == PCW'(PROG_CYCLES - 1)) begin
        busy_q <= 1'h0; // [RULE19]
      end else begin
        pcnt_q <= pcnt_q + PCW'(1);
      end
    end
  end

  // Whole-array operations sweep one word per cycle, well inside the program time.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sweep_q <= 1'h0;
      idx_q <= '0;
    end else if (launch) begin
      sweep_q <= 1'h1;
      idx_q <= ((cmd_kind_q == PG_WALL) || (cmd_kind_q == PG_EALL)) ? '0 : cmd_addr_q;
    end else if (sweep_q) begin
      if (((pkind_q != PG_WALL) && (pkind_q != PG_EALL)) || (idx_q == AW'(WORDS - 1))) begin
        sweep_q <= 1'h0;
      end else begin
        idx_q <= idx_q + AW'(1);
      end
    end
  end

  assign pat = ((pkind_q == PG_ERASE) || (pkind_q == PG_EALL)) ? `SEEP_ERASED : pdata_q; // [RULE1] [RULE3] [RULE5]

  always_ff @(posedge core_clk) begin
    if (sweep_q) begin
      mem[idx_q] <= pat;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  // Status stays on the pin until a start bit is seen once ready.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      verify_q <= 1'h0;
      do_q <= 1'h0;
      do_oe_q <= 1'h0;
    end else begin
      if (launch) begin
        verify_q <= 1'h1;
      end else if (!busy_q && (start_s != start_seen_q)) begin
        verify_q <= 1'h0; // [RULE12]
      end
      do_q <= !busy_q; // [RULE18]
      do_oe_q <= cs_s && (verify_q || launch) && !(!busy_q && (start_s != start_seen_q)); // [RULE18] [RULE12]
    end
  end

  assign link.do_val = do_q;
  // The start bit turns the pin off at its own edge; the synchronised core-side clear only follows later.
  assign link.do_oe = do_oe_q && (rx_q == RX_IDLE); // [RULE12]
  assign busy = busy_q;
  assign unlocked = unlock_s;
endmodule : seep_dev

// file: seep_host.sv
// Host end: builds frames, drives select, serial clock and data, and polls for ready.
`timescale 1ns/10ps
`include "seep_params.svh"
module seep_host
  import seep_pkg::*;
#(
  parameter int AW = `SEEP_ADDR_W,
  parameter int PAD_BITS = `SEEP_PAD_BITS,
  parameter int PWR_CYCLES = `SEEP_PWR_MS * (`SEEP_CLK_HZ / 1000),
  parameter int POLL_MAX = 2 * `SEEP_PROG_MS * (`SEEP_CLK_HZ / 1000)
) (
  input wire logic core_clk, // Core clock, 25 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  seep_if.host link, // Serial link; this end makes the serial clock.
  input wire logic cmd_valid, // Command request.
  output logic cmd_ready, // Ready to take a command.
  input wire seep_cmd_t cmd_kind, // Command kind.
  input wire logic [AW-1:0] cmd_addr, // Word address.
  input wire logic [`SEEP_WORD_W-1:0] cmd_data, // Data for word write and write-all.
  output logic done, // One-cycle pulse when a command has finished.
  output logic timed_out // Set ahead of done when polling never saw ready.
);
  localparam int DW = `SEEP_WORD_W;
  localparam int HB = 2 + AW;
  localparam int FW = 1 + HB + DW;
  localparam int HALF = `SEEP_SK_HALF;
  localparam int GAP_CYCLES = (`SEEP_CS_LOW_NS * (`SEEP_CLK_HZ / 1000000) + 999) / 1000;
  localparam int CW = $clog2(PWR_CYCLES + POLL_MAX + 1);

  seep_host_t st_q;
  logic [CW-1:0] cnt_q;
  logic [FW-1:0] frame_q;
  logic [7:0] bit_q;
  logic [7:0] total_q;
  logic [7:0] ph_q;
  logic poll_q;
  logic cs_q;
  logic sk_q;
  logic di_q;
  logic do_s;
  logic [1:0] op_w;
  logic [AW-1:0] addr_w;
  logic [7:0] len_w;

  seep_sync #(.W(1)) u_do_sync (
    .clk(core_clk),
    .rst(rst),
    .d(link.do_pin),
    .q(do_s)
  );

  always_comb begin
    op_w = `SEEP_OP_MISC;
    addr_w = cmd_addr;
    len_w = 8'(PAD_BITS + 1 + HB);
    case (cmd_kind)
      HC_LOCK: begin
        addr_w = {`SEEP_EXT_LOCK, (AW - 2)'(0)};
        len_w = 8'(PAD_BITS + 2 + HB); // [RULE8]
      end
      HC_UNLOCK: begin
        addr_w = {`SEEP_EXT_UNLOCK, (AW - 2)'(0)};
        len_w = 8'(PAD_BITS + 2 + HB); // [RULE8]
      end
      HC_ERASE: op_w = `SEEP_OP_ERASE; // [RULE16]
      HC_WRITE: begin
        op_w = `SEEP_OP_WRITE;
        len_w = 8'(PAD_BITS + FW);
      end
      HC_WALL: begin
        addr_w = {`SEEP_EXT_WALL, (AW - 2)'(0)}; // [RULE16]
        len_w = 8'(PAD_BITS + FW); // [RULE4]
      end
      HC_EALL: addr_w = {`SEEP_EXT_EALL, (AW - 2)'(0)}; // [RULE5]
      default: op_w = `SEEP_OP_MISC;
    endcase
  end

  assign cmd_ready = (st_q == H_IDLE);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= H_PWR;
      cnt_q <= '0;
      frame_q <= '0;
      bit_q <= '0;
      total_q <= '0;
      ph_q <= '0;
      poll_q <= 1'h0;
      cs_q <= 1'h0; // [RULE9]
      sk_q <= 1'h0;
      di_q <= 1'h0;
      done <= 1'h0;
      timed_out <= 1'h0;
    end else begin
      done <= 1'h0;
      case (st_q)
        H_PWR: begin
          cnt_q <= cnt_q + CW'(1);
          if (cnt_q == CW'(PWR_CYCLES - 1)) begin
            st_q <= H_IDLE; // [RULE9]
          end
        end
        H_IDLE: begin
          if (cmd_valid) begin
            frame_q <= {`SEEP_START_BIT, op_w, addr_w, (cmd_kind == HC_WRITE || cmd_kind == HC_WALL) ? cmd_data : DW'(0)};
            total_q <= len_w;
            poll_q <= (cmd_kind != HC_LOCK) && (cmd_kind != HC_UNLOCK);
            bit_q <= '0;
            ph_q <= '0;
            cs_q <= 1'h1;
            st_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          ph_q <= (ph_q == 8'(2 * HALF - 1)) ? 8'h00 : ph_q + 8'h01;
          if (ph_q == 8'h00) begin
            if (bit_q < 8'(PAD_BITS)) begin
              di_q <= 1'h0; // [RULE10]
            end else begin
              di_q <= frame_q[FW-1];
              frame_q <= {frame_q[FW-2:0], 1'h0};
            end
          end
          if (ph_q == 8'(HALF - 1)) begin
            sk_q <= 1'h1;
          end
          if (ph_q == 8'(2 * HALF - 1)) begin
            sk_q <= 1'h0;
            bit_q <= bit_q + 8'h01;
            if (bit_q == total_q - 8'h01) begin
              cs_q <= 1'h0; // [RULE2] [RULE4] [RULE5]
              di_q <= 1'h0;
              cnt_q <= '0;
              st_q <= H_GAP;
            end
          end
        end
        H_GAP: begin
          cnt_q <= cnt_q + CW'(1);
          if (cnt_q >= CW'(GAP_CYCLES - 1)) begin
            cnt_q <= '0;
            if (poll_q) begin
              poll_q <= 1'h0;
              cs_q <= 1'h1;
              st_q <= H_POLL;
            end else begin
              done <= 1'h1;
              st_q <= H_IDLE;
            end
          end
        end
        H_POLL: begin
          di_q <= 1'h0; // [RULE11]
          cnt_q <= cnt_q + CW'(1);
          if ((cnt_q >= CW'(`SEEP_POLL_SETTLE)) && do_s) begin
            timed_out <= 1'h0;
            cs_q <= 1'h0;
            cnt_q <= '0;
            st_q <= H_GAP;
          end else if (cnt_q == CW'(POLL_MAX - 1)) begin
            timed_out <= 1'h1;
            cs_q <= 1'h0;
            cnt_q <= '0;
            st_q <= H_GAP;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.cs = cs_q;
  assign link.sk = sk_q;
  assign link.di = di_q;
endmodule : seep_host

// file: seep_monitor.sv
// Concurrent checks on the host-to-device serial link.
`timescale 1ns/10ps
module seep_monitor #(
  parameter int PWR_CYCLES = 50,
  parameter int PROG_CYCLES = 200
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic cs, // Chip select.
  input wire logic sk, // Serial clock.
  input wire logic di, // Serial data to the device.
  input wire logic do_val, // Data-out value.
  input wire logic do_oe, // Data-out enable.
  input wire logic do_pin // Resolved data-out wire.
);
  int pwr_q;
  int bits_q;
  int busy_q;
  logic sk_q;
  logic sk_rise;

  // The serial clock comes from a core-clock divider, so edges are seen cleanly here.
  assign sk_rise = sk && !sk_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sk_q <= 1'h0;
    end else begin
      sk_q <= sk;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_q <= 0;
    end else if (pwr_q < PWR_CYCLES) begin
      pwr_q <= pwr_q + 1;
    end
  end

  // Counts serial clock rises within one select period; polling periods must count none.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bits_q <= 0;
    end else if (!cs) begin
      bits_q <= 0;
    end else if (sk_rise) begin
      bits_q <= bits_q + 1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 0;
    end else begin
      busy_q <= (do_oe && !do_val) ? busy_q + 1 : 0;
    end
  end

  chk_pwr_quiet: assert property (@(posedge core_clk) disable iff (rst)
    pwr_q < PWR_CYCLES |-> !cs) else $error("select raised during power-up wait");
  chk_poll_di_low: assert property (@(posedge core_clk) disable iff (rst)
    do_oe |-> !di) else $error("data input high while status is driven");
  chk_busy_first: assert property (@(posedge core_clk) disable iff (rst)
    $rose(do_oe) |-> !do_val) else $error("status did not start as busy");
  chk_ready_stays: assert property (@(posedge core_clk) disable iff (rst)
    do_oe && do_pin |=> !do_oe || do_pin) else $error("status fell back to busy");
  chk_prog_bound: assert property (@(posedge core_clk) disable iff (rst)
    busy_q <= PROG_CYCLES) else $error("program cycle ran too long");
  chk_frame_len: assert property (@(posedge core_clk) disable iff (rst)
    $fell(cs) |-> bits_q inside {0, 9, 10, 25}) else $error("frame length wrong");
  chk_start_first: assert property (@(posedge core_clk) disable iff (rst)
    cs && sk_rise && bits_q == 0 |-> di) else $error("first bit of frame not a start bit");
  chk_cs_gap: assert property (@(posedge core_clk) disable iff (rst)
    $fell(cs) |-> !cs [*8]) else $error("select low gap too short");
  chk_di_stable: assert property (@(posedge core_clk) disable iff (rst)
    sk && $past(sk) |-> $stable(di)) else $error("data changed while clock high");
endmodule : seep_monitor

// file: testbench.sv
// Bench: host and device joined on one link, and a bench-driven link to a second device.
`timescale 1ns/10ps
module testbench;
  import seep_pkg::*;
  localparam int PWR = 50;
  localparam int PROG = 200;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0;
  seep_cmd_t cmd_kind = HC_LOCK;
  logic [5:0] cmd_addr = 6'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic [5:0] rd_addr = 6'h00;
  logic cmd_ready, done, timed_out, busy1, busy2, unl1, unl2, saw_busy;
  logic [15:0] rd1, rd2;
  int fails = 0;
  int total_checks = 0;
  int k;
  seep_if link1 ();
  seep_if link2 ();

  always #20 core_clk = ~core_clk;

  seep_host #(.PWR_CYCLES(PWR), .POLL_MAX(400)) seep_host_inst (.core_clk(core_clk), .rst(rst),
    .link(link1.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .done(done), .timed_out(timed_out));
  seep_dev #(.PROG_CYCLES(PROG)) seep_dev_inst (.core_clk(core_clk), .rst(rst), .link(link1.dev),
    .rd_addr(rd_addr), .rd_data(rd1), .busy(busy1), .unlocked(unl1));
  seep_dev #(.PROG_CYCLES(PROG)) seep_dev_inst2 (.core_clk(core_clk), .rst(rst), .link(link2.dev),
    .rd_addr(rd_addr), .rd_data(rd2), .busy(busy2), .unlocked(unl2));
  seep_monitor #(.PWR_CYCLES(PWR), .PROG_CYCLES(PROG)) seep_monitor_inst (.core_clk(core_clk),
    .rst(rst), .cs(link1.cs), .sk(link1.sk), .di(link1.di), .do_val(link1.do_val),
    .do_oe(link1.do_oe), .do_pin(link1.do_pin));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_word

  // Bounded waits: a hang counts as a mismatch and ends the run at once.
  task automatic give_up(input int i, input int lim);
    if (i >= lim) begin
      fails++;
      $display("wrong value wait bound expected below %0d seen %0d", lim, i);
      test_done();
    end
  endtask : give_up

  task automatic run_cmd(input seep_cmd_t kind, input logic [5:0] a, input logic [15:0] d);
    int i = 0;
    saw_busy = 1'h0;
    @(negedge core_clk);
    cmd_kind = kind;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    @(negedge core_clk);
    cmd_valid = 1'h0;
    while (done !== 1'h1 && i < 6000) begin
      @(posedge core_clk);
      #1;
      saw_busy = saw_busy | busy1;
      i++;
    end
    give_up(i, 6000);
    cmp_bit("timed_out", 1'h0, timed_out);
  endtask : run_cmd

  task automatic word_is(input logic which, input logic [5:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    rd_addr = a;
    @(negedge core_clk);
    cmp_word("stored word", exp, which ? rd2 : rd1);
  endtask : word_is

  // The bench link clock runs only inside frames and idles low between them.
  task automatic tx(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      link2.di = v[i];
      #40;
      link2.sk = 1'h1;
      #80;
      link2.sk = 1'h0;
      #40;
    end
    link2.di = 1'h0;
  endtask : tx

  // The odd start offset keeps the link clock out of step with the core clock.
  task automatic frame(input int n, input logic [31:0] v, input logic drop);
    #13;
    link2.cs = 1'h1;
    #200;
    tx(n, v);
    if (drop) begin
      link2.cs = 1'h0;
      #600;
    end
  endtask : frame

  task automatic poll_ready();
    int i = 0;
    #13;
    link2.cs = 1'h1;
    repeat (8) @(negedge core_clk);
    cmp_bit("status while busy", 1'h0, link2.do_pin);
    cmp_bit("second busy", 1'h1, busy2);
    while (link2.do_pin !== 1'h1 && i < 1000) begin
      @(negedge core_clk);
      i++;
    end
    give_up(i, 1000);
    cmp_bit("second busy", 1'h0, busy2);
  endtask : poll_ready

  initial begin
    link2.cs = 1'h0;
    link2.sk = 1'h0;
    link2.di = 1'h0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'h0;
    cmp_bit("program latch", 1'h0, unl1);
    run_cmd(HC_WALL, 6'h00, 16'ha5c3);
    cmp_bit("busy seen", 1'h0, saw_busy);
    run_cmd(HC_UNLOCK, 6'h00, 16'h0000);
    cmp_bit("program latch", 1'h1, unl1);
    run_cmd(HC_WALL, 6'h15, 16'ha5c3);
    cmp_bit("busy seen", 1'h1, saw_busy);
    for (k = 0; k < 64; k++) word_is(1'h0, k[5:0], 16'ha5c3);
    run_cmd(HC_ERASE, 6'h05, 16'h0000);
    word_is(1'h0, 6'h05, 16'hffff);
    word_is(1'h0, 6'h04, 16'ha5c3);
    run_cmd(HC_WRITE, 6'h06, 16'h0f0f);
    word_is(1'h0, 6'h06, 16'h0f0f);
    run_cmd(HC_EALL, 6'h00, 16'h0000);
    for (k = 0; k < 64; k++) word_is(1'h0, k[5:0], 16'hffff);
    run_cmd(HC_LOCK, 6'h00, 16'h0000);
    cmp_bit("program latch", 1'h0, unl1);
    run_cmd(HC_WRITE, 6'h06, 16'h0000);
    cmp_bit("busy seen", 1'h0, saw_busy);
    word_is(1'h0, 6'h06, 16'hffff);
    $display("test host link done");
    cmp_bit("second latch", 1'h0, unl2);
    frame(12, {3'h0, 1'h1, 2'h0, 6'h30}, 1'h1);
    repeat (6) @(negedge core_clk);
    cmp_bit("second latch", 1'h0, unl2);
    frame(13, {3'h0, 1'h1, 2'h0, 6'h30, 1'h0}, 1'h0);
    repeat (6) @(negedge core_clk);
    cmp_bit("second latch", 1'h1, unl2);
    link2.cs = 1'h0;
    #600;
    frame(9, {1'h1, 2'h0, 6'h20}, 1'h1);
    poll_ready();
    link2.cs = 1'h0;
    #600;
    word_is(1'h1, 6'h03, 16'hffff);
    word_is(1'h1, 6'h28, 16'hffff);
    frame(24, {1'h1, 2'h1, 6'h03, 15'h0000}, 1'h1);
    repeat (300) @(negedge core_clk);
    word_is(1'h1, 6'h03, 16'hffff);
    frame(26, {1'h1, 2'h1, 6'h03, 16'h1234, 1'h1}, 1'h1);
    poll_ready();
    // Status is high here, so this start bit opens a new locking command in mid-poll.
    tx(1, 32'h0000_0001);
    cmp_bit("data-out enable at start", 1'h0, link2.do_oe);
    tx(9, {2'h0, 6'h00, 1'h0});
    repeat (6) @(negedge core_clk);
    cmp_bit("data-out enable", 1'h0, link2.do_oe);
    cmp_bit("second latch", 1'h0, unl2);
    link2.cs = 1'h0;
    #600;
    word_is(1'h1, 6'h03, 16'h1234);
    frame(9, {1'h1, 2'h3, 6'h03}, 1'h1);
    link2.cs = 1'h1;
    repeat (20) @(negedge core_clk);
    cmp_bit("data-out enable", 1'h0, link2.do_oe);
    link2.cs = 1'h0;
    #600;
    word_is(1'h1, 6'h03, 16'h1234);
    $display("test bench link done");
    test_done();
  end
endmodule : testbench
